// ---- inc/rtc_pkg.sv ----
/*
 * Constants shared by the byte-wide clock, calendar, watchdog and RAM block.
 * Assumes a single 200 MHz system clock drives all logic.
 */
package rtc_pkg;

    // Clock rate and timing figures
    localparam int unsigned CLK_HZ       = 200_000_000;
    localparam int unsigned TICK_US      = 10_000;      // Hundredth of a second
    localparam int unsigned TICK_CYC     = CLK_HZ / 1_000_000 * TICK_US;
    localparam int unsigned PWR_OK_MS    = 200;         // Supply-valid hold time
    localparam int unsigned PWR_OK_CYC   = CLK_HZ / 1_000 * PWR_OK_MS;
    localparam int unsigned SQW_HZ       = 1024;        // Square wave rate
    localparam int unsigned SQW_HALF_CYC = CLK_HZ / (2 * SQW_HZ);

    // Bus geometry
    localparam int unsigned ADDR_W   = 15;
    localparam int unsigned NUM_REGS = 14;

    // Register offsets
    localparam logic [3:0] OFS_HUND  = 4'h0;
    localparam logic [3:0] OFS_SEC   = 4'h1;
    localparam logic [3:0] OFS_MIN   = 4'h2;
    localparam logic [3:0] OFS_AMIN  = 4'h3;
    localparam logic [3:0] OFS_HOUR  = 4'h4;
    localparam logic [3:0] OFS_AHOUR = 4'h5;
    localparam logic [3:0] OFS_DAY   = 4'h6;
    localparam logic [3:0] OFS_ADAY  = 4'h7;
    localparam logic [3:0] OFS_DATE  = 4'h8;
    localparam logic [3:0] OFS_MONTH = 4'h9;
    localparam logic [3:0] OFS_YEAR  = 4'ha;
    localparam logic [3:0] OFS_CMD   = 4'hb;
    localparam logic [3:0] OFS_WDL   = 4'hc;
    localparam logic [3:0] OFS_WDH   = 4'hd;

    // Command register fields
    localparam int unsigned CMD_TE   = 7;
    localparam int unsigned CMD_IPSW = 6;
    localparam int unsigned CMD_IBH  = 5;
    localparam int unsigned CMD_WAM  = 3;
    localparam int unsigned CMD_TDM  = 2;
    localparam int unsigned CMD_WAF  = 1;
    localparam int unsigned CMD_TDF  = 0;

    // Other fields
    localparam int unsigned HR_12   = 6;   // 12-hour select
    localparam int unsigned HR_PM   = 5;   // PM or second tens-of-hours
    localparam int unsigned MON_OSC = 7;   // High stops oscillator
    localparam int unsigned MON_SQW = 6;   // High floats square wave
    localparam int unsigned AL_MASK = 7;   // Alarm mask bit

    // Reset values
    localparam logic [7:0] CMD_RST  = 8'h80;
    localparam logic [7:0] ZERO_RST = 8'h00;
    localparam logic [7:0] ONE_RST  = 8'h01;
    localparam logic [7:0] ADAY_WMASK = 8'h87;  // Writable bits of day alarm

endpackage : rtc_pkg

// ---- logic/rtc_top.sv ----
/*
 * Byte-wide timekeeper: clock/calendar, time-of-day alarm, watchdog,
 * square wave and user RAM, all behind an asynchronous SRAM-style port.
 * Assumes strobes and address arrive on pins that may be asynchronous;
 * commits are timed from synchronised strobes.
 */
`timescale 1ns/10ps

module rtc_top
    import rtc_pkg::*;
#(
    parameter int unsigned MEM_BYTES       = 32768,
    parameter int unsigned TICK_CYCLES     = TICK_CYC,
    parameter int unsigned PWR_OK_CYCLES   = PWR_OK_CYC,
    parameter int unsigned SQW_HALF_CYCLES = SQW_HALF_CYC
) (
    input  wire logic              clk_in,
    input  wire logic              rst_n_in,
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic [7:0]        data_io_in,
    output logic      [7:0]        data_io_out,
    output logic                   data_io_oe_out,
    input  wire logic              ce_n_in,
    input  wire logic              oe_n_in,
    input  wire logic              we_n_in,
    input  wire logic              power_fail_in,
    output logic                   irq_out_first_out,
    output logic                   irq_out_first_oe_out,
    output logic                   irq_out_second_out,
    output logic                   irq_out_second_oe_out,
    output logic                   square_wave_out,
    output logic                   square_wave_oe_out
);

    localparam int unsigned AW = $clog2(MEM_BYTES);

    // Registers at the bottom of the map
    function automatic logic is_reg(input logic [AW-1:0] a);
        is_reg = (a < AW'(NUM_REGS));
    endfunction : is_reg

    // BCD increment, wrapping from hi to lo; bit 8 is the carry
    function automatic logic [8:0] bcd_inc(input logic [7:0] v,
                                           input logic [7:0] lo,
                                           input logic [7:0] hi);
        if (v == hi) begin
            bcd_inc = {1'b1, lo};
        end else if (v[3:0] == 4'h9) begin
            bcd_inc = {1'b0, v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_inc = {1'b0, v + 8'h01};
        end
    endfunction : bcd_inc

    // BCD seconds.hundredths to binary hundredths
    function automatic logic [13:0] bcd2bin(input logic [15:0] b);
        bcd2bin = 14'(b[15:12] * 1000 + b[11:8] * 100 + b[7:4] * 10 + b[3:0]);
    endfunction : bcd2bin

    // Storage
    logic [7:0] mem_r [0:MEM_BYTES-1];  // User bytes
    logic [7:0] ext_r [0:NUM_REGS-1];   // User-visible registers
    logic [7:0] int_r [0:NUM_REGS-1];   // Internal time copies

    // Bus strobes
    logic          wr_raw;              // Both write strobes low
    logic          rd_raw;              // Read pattern present
    logic          wr_meta_r;           // Sync stage one
    logic          wr_sync_r;           // Sync stage two
    logic          wr_prev_r;           // Edge history
    logic          rd_meta_r;
    logic          rd_sync_r;
    logic          rd_prev_r;
    logic [AW-1:0] wr_addr_r;           // Address held for commit
    logic [7:0]    wr_data_r;           // Data at closing edge
    logic          commit;              // One-cycle write commit
    logic          rd_start;            // One-cycle read begin
    logic [AW-1:0] rd_addr;

    // Supply guard
    logic [25:0]   pwr_cnt_r;
    logic          wr_ok_r;

    // Timebase
    logic [20:0]   tick_cnt_r;
    logic          tick_due;
    logic          tick;
    logic [16:0]   sqw_cnt_r;
    logic          sqw_r;
    logic          osc_on;

    // Watchdog
    logic [13:0]   wd_cnt_r;
    logic [13:0]   wd_load;
    logic          wd_touch;
    logic          wd_fire;

    // Alarm
    logic          al_touch;
    logic          tod_fire;

    // Next internal time
    logic [8:0] hund_n, sec_n, min_n, day_n, date_n, mon_n, year_n, h24_n;
    logic [7:0] hour_n;
    logic [7:0] dim;
    logic       leap;
    logic       hr_carry;

    // Strobe decode; power fail makes every input a don't-care
    assign wr_raw = ~ce_n_in & ~we_n_in & ~power_fail_in;
    assign rd_raw = ~ce_n_in & ~oe_n_in & we_n_in & ~power_fail_in;
    assign rd_addr = addr_in[AW-1:0];

    // Two-flop synchronisers and edge history for both strobes
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            wr_meta_r <= 1'b0;
            wr_sync_r <= 1'b0;
            wr_prev_r <= 1'b0;
            rd_meta_r <= 1'b0;
            rd_sync_r <= 1'b0;
            rd_prev_r <= 1'b0;
        end else begin
            wr_meta_r <= wr_raw;
            wr_sync_r <= wr_meta_r;
            wr_prev_r <= wr_sync_r;
            rd_meta_r <= rd_raw;
            rd_sync_r <= rd_meta_r;
            rd_prev_r <= rd_sync_r;
        end
    end

    // Track address and data while the write overlap lasts
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            wr_addr_r <= '0;
            wr_data_r <= 8'h00;
        end else if (wr_raw) begin
            wr_addr_r <= addr_in[AW-1:0];
            wr_data_r <= data_io_in;
        end
    end

    // Commit at the closing edge, only when writes are allowed
    assign commit = wr_prev_r & ~wr_sync_r & wr_ok_r & ~power_fail_in;
    assign rd_start = rd_sync_r & ~rd_prev_r;

    // Supply must stay valid for the full guard time
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            pwr_cnt_r <= '0;
            wr_ok_r   <= 1'b0;
        end else if (power_fail_in) begin
            pwr_cnt_r <= '0;
            wr_ok_r   <= 1'b0;
        end else if (pwr_cnt_r == 26'(PWR_OK_CYCLES - 1)) begin
            wr_ok_r   <= 1'b1;
        end else begin
            pwr_cnt_r <= pwr_cnt_r + 26'h1;
        end
    end

    // Oscillator runs while its stop bit is low, supply state is ignored
    assign osc_on = ~int_r[OFS_MONTH][MON_OSC];

    // Hundredth tick; held due until no commit competes for the copies
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            tick_cnt_r <= '0;
        end else if (tick) begin
            tick_cnt_r <= '0;
        end else if (osc_on && !tick_due) begin
            tick_cnt_r <= tick_cnt_r + 21'h1;
        end
    end
    assign tick_due = (tick_cnt_r == 21'(TICK_CYCLES - 1));
    assign tick = tick_due & ~commit;

    // Square wave toggles at twice its rate while the clock runs
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            sqw_cnt_r <= '0;
            sqw_r     <= 1'b0;
        end else if (!osc_on) begin
            sqw_cnt_r <= '0;
        end else if (sqw_cnt_r == 17'(SQW_HALF_CYCLES - 1)) begin
            sqw_cnt_r <= '0;
            sqw_r     <= ~sqw_r;
        end else begin
            sqw_cnt_r <= sqw_cnt_r + 17'h1;
        end
    end
    assign square_wave_out    = sqw_r;
    assign square_wave_oe_out = ~ext_r[OFS_MONTH][MON_SQW];

    // Calendar: days in month and leap year from BCD year
    always_comb begin
        leap = int_r[OFS_YEAR][4] ? (int_r[OFS_YEAR][3:0] == 4'h2 ||
                                     int_r[OFS_YEAR][3:0] == 4'h6)
                                  : (int_r[OFS_YEAR][3:0] == 4'h0 ||
                                     int_r[OFS_YEAR][3:0] == 4'h4 ||
                                     int_r[OFS_YEAR][3:0] == 4'h8);
        case (int_r[OFS_MONTH][4:0])
            5'h02:   dim = leap ? 8'h29 : 8'h28;
            5'h04,
            5'h06,
            5'h09,
            5'h11:   dim = 8'h30;
            default: dim = 8'h31;
        endcase
    end

    // Carry chain through the internal copies
    always_comb begin
        hund_n = bcd_inc(int_r[OFS_HUND], 8'h00, 8'h99);
        sec_n  = bcd_inc(int_r[OFS_SEC], 8'h00, 8'h59);
        min_n  = bcd_inc(int_r[OFS_MIN], 8'h00, 8'h59);
        day_n  = bcd_inc(int_r[OFS_DAY], 8'h01, 8'h07);
        date_n = bcd_inc(int_r[OFS_DATE], 8'h01, dim);
        mon_n  = bcd_inc({3'b000, int_r[OFS_MONTH][4:0]}, 8'h01, 8'h12);
        year_n = bcd_inc(int_r[OFS_YEAR], 8'h00, 8'h99);
        h24_n  = bcd_inc({2'b00, int_r[OFS_HOUR][5:0]}, 8'h00, 8'h23);
        hour_n = int_r[OFS_HOUR];
        hr_carry = 1'b0;
        if (int_r[OFS_HOUR][HR_12]) begin
            // Twelve-hour: 11 to 12 flips meridian, 12 wraps to 1
            if (int_r[OFS_HOUR][4:0] == 5'h12) begin
                hour_n[4:0] = 5'h01;
            end else begin
                hour_n[4:0] = 5'(bcd_inc({3'b000, int_r[OFS_HOUR][4:0]},
                                        8'h01, 8'h12));
                if (int_r[OFS_HOUR][4:0] == 5'h11) begin
                    hour_n[HR_PM] = ~int_r[OFS_HOUR][HR_PM];
                    hr_carry = int_r[OFS_HOUR][HR_PM];
                end
            end
        end else begin
            // Twenty-four hour: bit 5 is the second tens bit
            hour_n[5:0] = h24_n[5:0];
            hr_carry    = h24_n[8];
        end
    end

    // Alarm checked as the minute turns over, masks widen the match
    assign tod_fire = tick & hund_n[8] & sec_n[8] &
                      (ext_r[OFS_AMIN][AL_MASK] |
                       (min_n[7:0] == {1'b0, ext_r[OFS_AMIN][6:0]})) &
                      (ext_r[OFS_AHOUR][AL_MASK] |
                       (int_r[OFS_HOUR][5:0] == ext_r[OFS_AHOUR][5:0])) &
                      (ext_r[OFS_ADAY][AL_MASK] |
                       (int_r[OFS_DAY][2:0] == ext_r[OFS_ADAY][2:0]));

    // Alarm flag cleared by any access to the alarm settings
    assign al_touch = (commit && (wr_addr_r == AW'(OFS_AMIN) ||
                                  wr_addr_r == AW'(OFS_AHOUR) ||
                                  wr_addr_r == AW'(OFS_ADAY))) ||
                      (rd_start && (rd_addr == AW'(OFS_AMIN) ||
                                    rd_addr == AW'(OFS_AHOUR) ||
                                    rd_addr == AW'(OFS_ADAY)));

    // Watchdog reload on any access to its interval bytes
    assign wd_touch = (commit && (wr_addr_r == AW'(OFS_WDL) ||
                                  wr_addr_r == AW'(OFS_WDH))) ||
                      (rd_start && (rd_addr == AW'(OFS_WDL) ||
                                    rd_addr == AW'(OFS_WDH)));
    assign wd_load = bcd2bin({ext_r[OFS_WDH], ext_r[OFS_WDL]});
    assign wd_fire = tick & (wd_load != 14'h0) & (wd_cnt_r == 14'h1);

    // Watchdog countdown in hundredths, repeats while untouched
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            wd_cnt_r <= '0;
        end else if (wd_touch) begin
            wd_cnt_r <= wd_load;
        end else if (tick && wd_load != 14'h0) begin
            if (wd_cnt_r <= 14'h1) begin
                wd_cnt_r <= wd_load;
            end else begin
                wd_cnt_r <= wd_cnt_r - 14'h1;
            end
        end
    end

    // Internal time: ticks and host writes to time bytes
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                int_r[i] <= ZERO_RST;
            end
            int_r[OFS_DAY]   <= ONE_RST;
            int_r[OFS_DATE]  <= ONE_RST;
            int_r[OFS_MONTH] <= ONE_RST;
        end else if (commit && is_reg(wr_addr_r)) begin
            int_r[wr_addr_r[3:0]] <= wr_data_r;
        end else if (tick) begin
            int_r[OFS_HUND] <= hund_n[7:0];
            if (hund_n[8]) begin
                int_r[OFS_SEC] <= sec_n[7:0];
                if (sec_n[8]) begin
                    int_r[OFS_MIN] <= min_n[7:0];
                    if (min_n[8]) begin
                        int_r[OFS_HOUR] <= hour_n;
                        if (hr_carry) begin
                            int_r[OFS_DAY]  <= day_n[7:0];
                            int_r[OFS_DATE] <= date_n[7:0];
                            if (date_n[8]) begin
                                int_r[OFS_MONTH][4:0] <= mon_n[4:0];
                                if (mon_n[8]) begin
                                    int_r[OFS_YEAR] <= year_n[7:0];
                                end
                            end
                        end
                    end
                end
            end
        end
    end

    // User-visible registers: host writes, copy-out, command flags
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                ext_r[i] <= ZERO_RST;
            end
            ext_r[OFS_DAY]   <= ONE_RST;
            ext_r[OFS_DATE]  <= ONE_RST;
            ext_r[OFS_MONTH] <= ONE_RST;
            ext_r[OFS_CMD]   <= CMD_RST;
        end else begin
            if (commit && is_reg(wr_addr_r)) begin
                if (wr_addr_r == AW'(OFS_CMD)) begin
                    ext_r[OFS_CMD][7:2] <= wr_data_r[7:2];
                end else if (wr_addr_r == AW'(OFS_ADAY)) begin
                    ext_r[OFS_ADAY] <= wr_data_r & ADAY_WMASK;
                end else begin
                    ext_r[wr_addr_r[3:0]] <= wr_data_r;
                end
            end else if (tick && ext_r[OFS_CMD][CMD_TE]) begin
                // All time bytes refreshed in the same edge
                for (int i = 0; i <= int'(OFS_YEAR); i++) begin
                    if (i != int'(OFS_AMIN) && i != int'(OFS_AHOUR) &&
                        i != int'(OFS_ADAY)) begin
                        ext_r[i] <= int_r[i];
                    end
                end
            end
            // Flags: a setting event wins over an access clear
            ext_r[OFS_CMD][CMD_TDF] <= tod_fire |
                                       (ext_r[OFS_CMD][CMD_TDF] & ~al_touch);
            ext_r[OFS_CMD][CMD_WAF] <= wd_fire |
                                       (ext_r[OFS_CMD][CMD_WAF] & ~wd_touch);
        end
    end

    // User RAM above the register block
    always_ff @(posedge clk_in) begin
        if (commit && !is_reg(wr_addr_r)) begin
            mem_r[wr_addr_r] <= wr_data_r;
        end
    end

    // Read data registered from the addressed byte
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            data_io_out <= 8'h00;
        end else if (is_reg(rd_addr)) begin
            data_io_out <= ext_r[rd_addr[3:0]];
        end else begin
            data_io_out <= mem_r[rd_addr];
        end
    end

    // Drivers on only while the read pattern holds
    assign data_io_oe_out = rd_raw;

    // Interrupt pins follow the flags whatever the supply does
    always_ff @(posedge clk_in) begin
        logic tod_act;
        logic wd_act;
        logic first;
        logic second;
        tod_act = ext_r[OFS_CMD][CMD_TDF] & ~ext_r[OFS_CMD][CMD_TDM];
        wd_act  = ext_r[OFS_CMD][CMD_WAF] & ~ext_r[OFS_CMD][CMD_WAM];
        first   = ext_r[OFS_CMD][CMD_IPSW] ? tod_act : wd_act;
        second  = ext_r[OFS_CMD][CMD_IPSW] ? wd_act : tod_act;
        if (!rst_n_in) begin
            irq_out_first_oe_out  <= 1'b0;
            irq_out_second_out    <= 1'b0;
            irq_out_second_oe_out <= 1'b0;
        end else begin
            irq_out_first_oe_out <= first;
            if (ext_r[OFS_CMD][CMD_IBH]) begin
                irq_out_second_out    <= second;
                irq_out_second_oe_out <= 1'b1;
            end else begin
                irq_out_second_out    <= 1'b0;
                irq_out_second_oe_out <= second;
            end
        end
    end

    // First interrupt pin only ever sinks
    assign irq_out_first_out = 1'b0;

endmodule : rtc_top

// ---- dv/rtc_top_props.sv ----
/* Port checker for rtc_top: bus drive, power-fail and timer liveness.
   Assumes one clock domain and a synchronous active-low reset. */
`timescale 1ns/10ps
module rtc_top_props
    import rtc_pkg::*;
#(
    parameter int unsigned SQW_HALF_CYCLES = 4  // Square wave half period
) (
    input wire logic              clk_in,
    input wire logic              rst_n_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic              ce_n_in,
    input wire logic              oe_n_in,
    input wire logic              we_n_in,
    input wire logic              power_fail_in,
    input wire logic [7:0]        data_io_out,
    input wire logic              data_io_oe_out,
    input wire logic              irq_out_first_out,
    input wire logic              irq_out_first_oe_out,
    input wire logic              square_wave_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // Long RAM read with a steady address
    sequence ram_read_s;
        !ce_n_in && !oe_n_in && we_n_in && !power_fail_in && addr_in >= 15'h000e
            && $stable(addr_in);
    endsequence
    a_read_drive: assert property (data_io_oe_out == (!ce_n_in && !oe_n_in && we_n_in
        && !power_fail_in)) else $error("drive enable wrong");
    a_we_off: assert property ($fell(we_n_in) |-> !data_io_oe_out)
        else $error("drivers stay on at write");
    a_pf_quiet: assert property (power_fail_in[*2] |-> !data_io_oe_out)
        else $error("bus active in power fail");
    a_read_stable: assert property (ram_read_s[*6] |-> $stable(data_io_out))
        else $error("read data moves");
    a_sqw_period: assert property ($changed(square_wave_out) |=>
        $stable(square_wave_out)[*3] ##1 $changed(square_wave_out)) else $error("sqw period");
    a_pf_clock: assert property (power_fail_in |-> ##[1:5] $changed(square_wave_out))
        else $error("clock stops in power fail");
    a_irq_sink: assert property (irq_out_first_out == 1'b0)
        else $error("first irq drives high");
    a_irq_hold: assert property ((power_fail_in && irq_out_first_oe_out)[*5]
        |=> irq_out_first_oe_out) else $error("irq lost in power fail");
    c_read: cover property (ram_read_s[*6]);
    c_irq: cover property ($rose(irq_out_first_oe_out));
    c_pf: cover property ($fell(power_fail_in));
endmodule : rtc_top_props

bind rtc_top rtc_top_props #(.SQW_HALF_CYCLES(SQW_HALF_CYCLES)) u_rtc_top_props (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .ce_n_in(ce_n_in),
    .oe_n_in(oe_n_in), .we_n_in(we_n_in), .power_fail_in(power_fail_in),
    .data_io_out(data_io_out), .data_io_oe_out(data_io_oe_out),
    .irq_out_first_out(irq_out_first_out), .irq_out_first_oe_out(irq_out_first_oe_out),
    .square_wave_out(square_wave_out));

// ---- dv/host_bus_model.sv ----
/* Host processor model on the asynchronous byte-wide bus.
   Assumes the bench calls wr and rd one at a time. */
`timescale 1ns/10ps
module host_bus_model
    import rtc_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic [7:0]        rdata_in,
    output logic      [ADDR_W-1:0] addr_out,
    output logic      [7:0]        wdata_out,
    output logic                   ce_n_out,
    output logic                   oe_n_out,
    output logic                   we_n_out
);
    // Idle bus at time zero
    initial begin
        addr_out = '0;
        wdata_out = 8'hff;
        {ce_n_out, oe_n_out, we_n_out} = 3'b111;
    end
    // Write: overlap of three clocks, address and data held past the end
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clk_in);
        #1;
        addr_out = a;
        wdata_out = d;
        oe_n_out = 1'b1;
        {ce_n_out, we_n_out} = 2'b00;
        repeat (3) @(posedge clk_in);
        #1;
        {ce_n_out, we_n_out} = 2'b11;
        @(posedge clk_in);
        #1;
        wdata_out = ~d;
        repeat (4) @(posedge clk_in);
    endtask : wr
    // Read: long enough for access side effects to land
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
        @(posedge clk_in);
        #1;
        addr_out = a;
        {ce_n_out, oe_n_out} = 2'b00;
        repeat (7) @(posedge clk_in);
        @(negedge clk_in);
        d = rdata_in;
        @(posedge clk_in);
        #1;
        {ce_n_out, oe_n_out} = 2'b11;
        repeat (4) @(posedge clk_in);
    endtask : rd
endmodule : host_bus_model

// ---- dv/bytewide_rtc_watchdog_nvram_tb_top.sv ----
/* Self-checking bench for rtc_top driven through the host model.
   Assumes shortened tick, guard and square wave counts. */
`timescale 1ns/10ps
module bytewide_rtc_watchdog_nvram_tb_top
    import rtc_pkg::*;
;
    logic              clk_in = 1'b0;
    logic              rst_n_in = 1'b0;
    logic              power_fail_in = 1'b0;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata, rdata, d1;
    logic              ce_n, oe_n, we_n, irq_oe, irq2_oe;
    int                miscompares = 0, n_checks = 0, cyc = 0, cnt;

    always #2.5 clk_in = ~clk_in;

    rtc_top #(.TICK_CYCLES(20), .PWR_OK_CYCLES(10), .SQW_HALF_CYCLES(4)) u_rtc_top (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr), .data_io_in(wdata),
        .data_io_out(rdata), .data_io_oe_out(), .ce_n_in(ce_n), .oe_n_in(oe_n),
        .we_n_in(we_n), .power_fail_in(power_fail_in), .irq_out_first_out(),
        .irq_out_first_oe_out(irq_oe), .irq_out_second_out(), .irq_out_second_oe_out(irq2_oe),
        .square_wave_out(), .square_wave_oe_out());
    host_bus_model u_host_bus_model (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr),
        .wdata_out(wdata), .ce_n_out(ce_n), .oe_n_out(oe_n), .we_n_out(we_n));

    // Verdict and end of run
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop
    // Preload one hundredth before midnight, wait for carry and copy-out
    task automatic near_midnight(input logic [7:0] hr);
        u_host_bus_model.wr(15'h0000, 8'h00);
        u_host_bus_model.wr(15'h0004, hr);
        u_host_bus_model.wr(15'h0002, 8'h59);
        u_host_bus_model.wr(15'h0001, 8'h59);
        u_host_bus_model.wr(15'h0000, 8'h99);
        repeat (50) @(posedge clk_in);
    endtask : near_midnight
    // Compare one byte
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask : chk
    // Read one byte and compare
    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [7:0] e, input string nm);
        logic [7:0] d;
        u_host_bus_model.rd(a, d);
        chk(nm, e, d);
    endtask : rdc
    // Hang guard
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            report_and_stop();
        end
    end

    initial begin
        repeat (8) @(posedge clk_in);
        #1 rst_n_in = 1'b1;
        rdc(15'h000b, CMD_RST, "cmd");
        rdc(15'h0006, ONE_RST, "day");
        rdc(15'h0008, ONE_RST, "date");
        rdc(15'h0009, ONE_RST, "month");
        $display("test reset_values done");
        u_host_bus_model.wr(15'h000e, 8'ha5);
        u_host_bus_model.wr(15'h7fff, 8'h3c);
        u_host_bus_model.wr(15'h3fff, 8'h5a);
        u_host_bus_model.wr(15'h0020, 8'h77);
        rdc(15'h000e, 8'ha5, "ram_low");
        rdc(15'h7fff, 8'h3c, "ram_top");
        rdc(15'h3fff, 8'h5a, "ram_mid");
        $display("test ram done");
        // Write under power fail, then inside the recovery guard
        #1 power_fail_in = 1'b1;
        u_host_bus_model.wr(15'h0020, 8'h11);
        #1 power_fail_in = 1'b0;
        u_host_bus_model.wr(15'h0020, 8'h22);
        rdc(15'h0020, 8'h77, "ram_protect");
        $display("test power_fail done");
        // Watchdog of five hundredths
        u_host_bus_model.wr(15'h000c, 8'h05);
        u_host_bus_model.wr(15'h000d, 8'h00);
        cnt = 0;
        while (irq_oe !== 1'b1 && cnt < 300) begin
            @(negedge clk_in);
            cnt++;
        end
        chk("wd_interval", 8'h01, {7'h00, cnt >= 55 && cnt <= 110});
        chk("irq2_idle", 8'h00, {7'h00, irq2_oe});
        rdc(15'h000b, 8'h82, "wd_flag");
        #1 power_fail_in = 1'b1;
        repeat (8) @(posedge clk_in);
        chk("irq_in_pf", 8'h01, {7'h00, irq_oe});
        #1 power_fail_in = 1'b0;
        repeat (12) @(posedge clk_in);
        rdc(15'h000c, 8'h05, "wd_readback");
        chk("irq_cleared", 8'h00, {7'h00, irq_oe});
        u_host_bus_model.wr(15'h000c, 8'h00);
        repeat (150) @(posedge clk_in);
        chk("wd_off", 8'h00, {7'h00, irq_oe});
        $display("test watchdog done");
        // Frozen copies, then running BCD hundredths
        u_host_bus_model.wr(15'h000b, 8'h00);
        u_host_bus_model.wr(15'h0000, 8'h42);
        repeat (60) @(posedge clk_in);
        rdc(15'h0000, 8'h42, "frozen");
        u_host_bus_model.wr(15'h000b, CMD_RST);
        for (int i = 0; i < 16; i++) begin
            u_host_bus_model.rd(15'h0000, d1);
            chk("bcd_digit", 8'h01, {7'h00, d1[3:0] <= 4'h9 && d1[7:4] <= 4'h9});
        end
        chk("running", 8'h01, {7'h00, d1 !== 8'h42});
        u_host_bus_model.wr(15'h0004, 8'h71);
        rdc(15'h0004, 8'h71, "hour_12h");
        near_midnight(8'h71);
        rdc(15'h0004, 8'h52, "hour_12h_roll");
        rdc(15'h0008, 8'h02, "date_12h_roll");
        near_midnight(8'h23);
        rdc(15'h0004, 8'h00, "hour_24h_roll");
        rdc(15'h0008, 8'h03, "date_24h_roll");
        $display("test time done");
        report_and_stop();
    end
endmodule : bytewide_rtc_watchdog_nvram_tb_top
